// *** design/gpio_p456_consts.svh ***
// constants for the port 3 to 6 pin logic
// Operation
// - port 4 eight pins, four regs, reset zero
// - direction 0 input, 1 output
// - pull-up bit 1 enables pull-up
// - open-drain bit 1 gives open-drain
// - port 6 bit 7 unimplemented
// - debounce enables in bits 4 to 0
// - level needs three agreeing samples
// - debounce suspended during stop mode
// - sample clock comes from port 1 field
// - clock field: fx, fx/4, fx/4096, sub
// - port 3 low: io, segment, serial
// - port 4 high: io, segment, timer, buzzer
// - port 4 low: io, segment, timer 0
// - port 5 high: io, segment, serial 1
// - port 5 low: io, segment, uart transmit
// - port 6 high: pin 5 io for receive
// - port 4 inputs feed interrupts, counters, select
// - port 5 inputs feed uart receive, select
// - port 6 inputs feed interrupts, counter, receive
`ifndef GPIO_P456_CONSTS_SVH
`define GPIO_P456_CONSTS_SVH
`define OFS_P4_PU 16'h009B
`define OFS_P5_PU 16'h009C
`define OFS_P6_PU 16'h009D
`define OFS_P4_DAT 16'h00A0
`define OFS_P5_DAT 16'h00B0
`define OFS_DB_EN 16'h00B7
`define OFS_P6_DAT 16'h00C0
`define OFS_P4_DIR 16'h00C9
`define OFS_P5_DIR 16'h00D1
`define OFS_P6_DIR 16'h00D9
`define OFS_P4_OD 16'h1004
`define OFS_P5_OD 16'h1005
`define OFS_P6_OD 16'h1006
`define OFS_P3_FL 16'h100E
`define OFS_P4_FL 16'h1010
`define OFS_P4_FH 16'h1011
`define OFS_P5_FL 16'h1012
`define OFS_P5_FH 16'h1013
`define OFS_P6_FH 16'h1015
`define MASK_P6 8'h7F
`define MASK_DB 8'h1F
`define MASK_P4_FL 8'h1F
`define MASK_P4_FH 8'h7F
`define MASK_P5_FL 8'h3F
`define MASK_P5_FH 8'h7F
`define MASK_P6_FH 8'h07
`define RESET_VAL 8'h00
`define DIV_SLOW 4096
`define DIV_FAST 4
`endif

// *** design/gpio_p456_pkg.sv ***
// types for the port 3 to 6 pin logic
package gpio_p456_pkg;
  typedef enum logic [1:0] {
    DEBOUNCE_CLOCK_SELECT_FX = 2'b00,
    DEBOUNCE_CLOCK_SELECT_FX4 = 2'b01,
    DEBOUNCE_CLOCK_SELECT_FX4096 = 2'b10,
    DEBOUNCE_CLOCK_SELECT_SUB = 2'b11
  } debounce_clock_select_t;
  typedef struct packed {
    logic [7:0] p4_dat, p4_dir, p4_pu, p4_od;
    logic [7:0] p5_dat, p5_dir, p5_pu, p5_od;
    logic [7:0] p6_dat, p6_dir, p6_pu, p6_od;
    logic [7:0] db_en, p3_fl, p4_fl, p4_fh, p5_fl, p5_fh, p6_fh;
    logic [31:0] rdat;
    logic ack;
    logic [11:0] div;
    logic [2:0] sub_s;
    logic tick;
    logic [22:0] s1, s2, s3;
    logic [4:0] filt;
    logic [1:0] c0, c1, c2, c3, c4;
    logic [22:0] pin_out, pin_oe, pin_pu;
    logic [3:0] p3_own;
    logic [22:0] pin_in;
    logic [22:0] gate;
  } state_t;
endpackage

// *** design/gpio_p456.sv ***
// port 3 to 6 pin control, debounce and function steering
`timescale 1ns/10ps
`include "gpio_p456_consts.svh"
module gpio_p456
  import gpio_p456_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] debounce_clock_select_i,
  input wire logic sub_clk_i,
  input wire logic stop_mode_i,
  input wire logic [22:0] pin_in_i,
  output logic [22:0] pin_out_o,
  output logic [22:0] pin_oe_o,
  output logic [22:0] pin_pu_o,
  input wire logic [22:0] periph_out_i,
  input wire logic [22:0] periph_oe_i,
  output logic [22:0] pin_filtered_o,
  output logic [3:0] p3_periph_sel_o
);
  // pins: [7:0] port 4, [15:8] port 5, [22:16] port 6 bits 6:0
  state_t q, d;
  logic [22:0] io_mode;
  logic [22:0] pdat, pdir, pod;
  logic [22:0] eff;
  logic [7:0] wbyte;
  logic hit;

  function automatic logic is_io2(input logic [1:0] f);
    return f == 2'b00;
  endfunction

  // run length of a level that differs from the accepted one
  function automatic logic [1:0] filt_cnt(input logic [1:0] c,
      input logic cur, input logic smp);
    if (smp == cur) return 2'd0;
    if (c == 2'd2) return 2'd0;
    return c + 2'd1;
  endfunction

  // per-pin io-mode from the function select fields
  always_comb begin
    io_mode = '1;
    io_mode[0] = ~q.p4_fl[0];
    io_mode[1] = ~q.p4_fl[1];
    io_mode[2] = ~q.p4_fl[2];
    io_mode[3] = is_io2(q.p4_fl[4:3]);
    io_mode[4] = is_io2(q.p4_fh[1:0]);
    io_mode[5] = is_io2(q.p4_fh[3:2]);
    io_mode[6] = is_io2(q.p4_fh[5:4]);
    io_mode[7] = ~q.p4_fh[6];
    io_mode[8] = ~q.p5_fl[0];
    io_mode[9] = is_io2(q.p5_fl[2:1]);
    io_mode[10] = ~q.p5_fl[3];
    io_mode[11] = is_io2(q.p5_fl[5:4]);
    io_mode[12] = ~q.p5_fh[0];
    io_mode[13] = is_io2(q.p5_fh[2:1]);
    io_mode[14] = is_io2(q.p5_fh[4:3]);
    io_mode[15] = is_io2(q.p5_fh[6:5]);
    io_mode[21] = ~q.p6_fh[2];
  end

  assign pdat = {q.p6_dat[6:0], q.p5_dat, q.p4_dat};
  assign pdir = {q.p6_dir[6:0], q.p5_dir, q.p4_dir};
  assign pod = {q.p6_od[6:0], q.p5_od, q.p4_od};
  assign hit = wb_cyc_i & wb_stb_i & ~q.ack;
  assign wbyte = wb_dat_i[7:0];

  always_comb begin
    logic [7:0] rv;
    logic tk;
    rv = 8'h00;
    tk = 1'b0;
    d = q;
    d.ack = hit;
    d.rdat = 32'h0;
    unique case (wb_adr_i)
      `OFS_P4_PU: rv = q.p4_pu;
      `OFS_P5_PU: rv = q.p5_pu;
      `OFS_P6_PU: rv = q.p6_pu;
      `OFS_P4_DAT: rv = q.p4_dat;
      `OFS_P5_DAT: rv = q.p5_dat;
      `OFS_DB_EN: rv = q.db_en;
      `OFS_P6_DAT: rv = q.p6_dat;
      `OFS_P4_DIR: rv = q.p4_dir;
      `OFS_P5_DIR: rv = q.p5_dir;
      `OFS_P6_DIR: rv = q.p6_dir;
      `OFS_P4_OD: rv = q.p4_od;
      `OFS_P5_OD: rv = q.p5_od;
      `OFS_P6_OD: rv = q.p6_od;
      `OFS_P3_FL: rv = q.p3_fl;
      `OFS_P4_FL: rv = q.p4_fl;
      `OFS_P4_FH: rv = q.p4_fh;
      `OFS_P5_FL: rv = q.p5_fl;
      `OFS_P5_FH: rv = q.p5_fh;
      `OFS_P6_FH: rv = q.p6_fh;
      default: rv = 8'h00;
    endcase
    if (hit && !wb_we_i) begin
      d.rdat = {24'h0, rv};
    end
    if (hit && wb_we_i && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        `OFS_P4_PU: d.p4_pu = wbyte;
        `OFS_P5_PU: d.p5_pu = wbyte;
        `OFS_P6_PU: d.p6_pu = wbyte & `MASK_P6;
        `OFS_P4_DAT: d.p4_dat = wbyte;
        `OFS_P5_DAT: d.p5_dat = wbyte;
        `OFS_DB_EN: d.db_en = wbyte & `MASK_DB;
        `OFS_P6_DAT: d.p6_dat = wbyte & `MASK_P6;
        `OFS_P4_DIR: d.p4_dir = wbyte;
        `OFS_P5_DIR: d.p5_dir = wbyte;
        `OFS_P6_DIR: d.p6_dir = wbyte & `MASK_P6;
        `OFS_P4_OD: d.p4_od = wbyte;
        `OFS_P5_OD: d.p5_od = wbyte;
        `OFS_P6_OD: d.p6_od = wbyte & `MASK_P6;
        `OFS_P3_FL: d.p3_fl = wbyte;
        `OFS_P4_FL: d.p4_fl = wbyte & `MASK_P4_FL;
        `OFS_P4_FH: d.p4_fh = wbyte & `MASK_P4_FH;
        `OFS_P5_FL: d.p5_fl = wbyte & `MASK_P5_FL;
        `OFS_P5_FH: d.p5_fh = wbyte & `MASK_P5_FH;
        `OFS_P6_FH: d.p6_fh = wbyte & `MASK_P6_FH;
        default: d.p6_fh = q.p6_fh;
      endcase
    end
    // three-stage input capture, stages two and three agree
    d.s1 = pin_in_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.sub_s = {q.sub_s[1:0], sub_clk_i};
    // sample tick chosen by the port 1 clock field
    d.div = q.div + 12'd1;
    unique case (debounce_clock_select_t'(debounce_clock_select_i))
      DEBOUNCE_CLOCK_SELECT_FX: tk = 1'b1;
      DEBOUNCE_CLOCK_SELECT_FX4: tk = (q.div[1:0] == 2'(`DIV_FAST - 1));
      DEBOUNCE_CLOCK_SELECT_FX4096: tk = (q.div == 12'(`DIV_SLOW - 1));
      DEBOUNCE_CLOCK_SELECT_SUB: tk = q.sub_s[1] & ~q.sub_s[2];
    endcase
    d.tick = tk;
    // settled synchronised level, used when filter off
    for (int i = 0; i < 23; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.pin_in[i] = q.s3[i];
      end
    end
    // filter: a new level must be seen on three ticks in a row
    if (q.tick && !stop_mode_i) begin
      d.c0 = filt_cnt(q.c0, q.filt[0], d.pin_in[3]);
      d.c1 = filt_cnt(q.c1, q.filt[1], d.pin_in[4]);
      d.c2 = filt_cnt(q.c2, q.filt[2], d.pin_in[5]);
      d.c3 = filt_cnt(q.c3, q.filt[3], d.pin_in[17]);
      d.c4 = filt_cnt(q.c4, q.filt[4], d.pin_in[18]);
      if (q.c0 == 2'd2 && d.pin_in[3] != q.filt[0]) begin
        d.filt[0] = d.pin_in[3];
      end
      if (q.c1 == 2'd2 && d.pin_in[4] != q.filt[1]) begin
        d.filt[1] = d.pin_in[4];
      end
      if (q.c2 == 2'd2 && d.pin_in[5] != q.filt[2]) begin
        d.filt[2] = d.pin_in[5];
      end
      if (q.c3 == 2'd2 && d.pin_in[17] != q.filt[3]) begin
        d.filt[3] = d.pin_in[17];
      end
      if (q.c4 == 2'd2 && d.pin_in[18] != q.filt[4]) begin
        d.filt[4] = d.pin_in[18];
      end
    end
    // pin drive: peripheral owns pin outside io mode
    for (int i = 0; i < 23; i++) begin
      if (io_mode[i]) begin
        d.pin_oe[i] = pdir[i] & ~(pod[i] & pdat[i]);
        d.pin_out[i] = pdat[i] & ~pod[i];
      end else begin
        d.pin_oe[i] = periph_oe_i[i];
        d.pin_out[i] = periph_out_i[i];
      end
    end
    d.pin_pu = {q.p6_pu[6:0], q.p5_pu, q.p4_pu};
    for (int i = 0; i < 4; i++) begin
      d.p3_own[i] = q.p3_fl[2*i +: 2] != 2'b00;
    end
    // peripheral inputs only see pins in io mode, input direction
    d.gate = eff & io_mode & ~pdir;
  end

  // filtered levels feed interrupt, counter and receive inputs
  always_comb begin
    eff = q.pin_in;
    eff[3] = q.db_en[0] ? q.filt[0] : q.pin_in[3];
    eff[4] = q.db_en[1] ? q.filt[1] : q.pin_in[4];
    eff[5] = q.db_en[2] ? q.filt[2] : q.pin_in[5];
    eff[17] = q.db_en[3] ? q.filt[3] : q.pin_in[17];
    eff[18] = q.db_en[4] ? q.filt[4] : q.pin_in[18];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o = q.rdat;
  assign wb_ack_o = q.ack;
  assign pin_out_o = q.pin_out;
  assign pin_oe_o = q.pin_oe;
  assign pin_pu_o = q.pin_pu;
  assign pin_filtered_o = q.gate;
  assign p3_periph_sel_o = q.p3_own;

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    s_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle after request");
  AST_P6_TOP: assert property (@(posedge clk_i) disable iff (rst_i)
    q.p6_dat[7] == 1'b0 && q.p6_dir[7] == 1'b0)
    else $error("port 6 bit 7 set");
  AST_DB_TOP: assert property (@(posedge clk_i) disable iff (rst_i)
    q.db_en[7:5] == 3'b000)
    else $error("debounce unused bits set");
  AST_OVERRIDE: assert property (@(posedge clk_i) disable iff (rst_i)
    !io_mode[7] |=> pin_oe_o[7] == $past(periph_oe_i[7]))
    else $error("peripheral not driving pin 7");
  AST_STOP: assert property (@(posedge clk_i) disable iff (rst_i)
    stop_mode_i |=> $stable(q.filt))
    else $error("filter moved in stop mode");
  AST_OD_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
    io_mode[0] && q.p4_od[0] && q.p4_dat[0] |=> !pin_oe_o[0])
    else $error("open drain drove high");
  AST_DIR_IN: assert property (@(posedge clk_i) disable iff (rst_i)
    io_mode[1] && !q.p4_dir[1] |=> !pin_oe_o[1])
    else $error("input pin driven");
  AST_FILT3: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(q.filt[0]) |-> $past(q.c0) == 2'd2)
    else $error("filter changed without three samples");
  AST_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
    q.p4_dir[3] |=> !pin_filtered_o[3])
    else $error("output pin fed to peripheral");

  // third differing tick on pin 3 of port 4
  sequence s_third;
    q.tick && !stop_mode_i && q.c0 == 2'd2 && d.pin_in[3] != q.filt[0];
  endsequence

  // a tick while the divide-by-four clock is chosen
  sequence s_fx4_tick;
    debounce_clock_select_i == 2'b01 && q.tick;
  endsequence

  // pin 3 of port 4 usable as a peripheral input
  sequence s_in_p4;
    io_mode[3] && !q.p4_dir[3];
  endsequence

  // bus side
  AST_RD_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o
    |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  AST_RD_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1
    |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  AST_P6_PU: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1
    |-> q.p6_pu[7] == 1'b0 && q.p6_od[7] == 1'b0)
    else $error("port 6 bit 7 set in pull-up or drain");
  AST_P4FL_TOP: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1
    |-> q.p4_fl[7:5] == 3'b000)
    else $error("port 4 low select unused bits set");
  AST_P4FH_TOP: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1
    |-> q.p4_fh[7] == 1'b0)
    else $error("port 4 high select bit 7 set");
  AST_P5FH_TOP: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1
    |-> q.p5_fh[7] == 1'b0)
    else $error("port 5 high select bit 7 set");
  AST_P5FL_TOP: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1
    |-> q.p5_fl[7:6] == 2'b00)
    else $error("port 5 low select unused bits set");
  AST_P6FH_TOP: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1
    |-> q.p6_fh[7:3] == 5'b00000)
    else $error("port 6 high select unused bits set");

  // pin drive
  AST_PUSH: assert property (@(posedge clk_i) disable iff (rst_i)
    io_mode[2] && q.p4_dir[2] && !q.p4_od[2]
    |=> pin_oe_o[2] && pin_out_o[2] == $past(q.p4_dat[2]))
    else $error("push-pull pin not driven with data");
  AST_PU: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1
    |-> pin_pu_o == $past({q.p6_pu[6:0], q.p5_pu, q.p4_pu}))
    else $error("pull-up enables do not follow register");
  AST_OD_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
    io_mode[0] && q.p4_od[0]
    |=> !pin_out_o[0])
    else $error("open drain pin drives a high level");
  AST_DIR_P5: assert property (@(posedge clk_i) disable iff (rst_i)
    io_mode[8] && !q.p5_dir[0]
    |=> !pin_oe_o[8])
    else $error("port 5 input pin driven");
  AST_DIR_P6: assert property (@(posedge clk_i) disable iff (rst_i)
    io_mode[16] && !q.p6_dir[0]
    |=> !pin_oe_o[16])
    else $error("port 6 input pin driven");

  // function steering
  AST_P3_SEL: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1
    |-> p3_periph_sel_o[0] == $past(q.p3_fl[1:0] != 2'b00))
    else $error("port 3 pin 0 owner wrong");
  AST_SEG_P4: assert property (@(posedge clk_i) disable iff (rst_i)
    !io_mode[3]
    |=> pin_out_o[3] == $past(periph_out_i[3]))
    else $error("peripheral not driving port 4 pin 3");
  AST_OVR_OE0: assert property (@(posedge clk_i) disable iff (rst_i)
    !io_mode[0]
    |=> pin_oe_o[0] == $past(periph_oe_i[0]))
    else $error("peripheral enable not on port 4 pin 0");
  AST_P4_HI: assert property (@(posedge clk_i) disable iff (rst_i)
    !io_mode[4]
    |=> pin_out_o[4] == $past(periph_out_i[4]))
    else $error("peripheral not driving port 4 pin 4");
  AST_P5_HI: assert property (@(posedge clk_i) disable iff (rst_i)
    !io_mode[13]
    |=> pin_oe_o[13] == $past(periph_oe_i[13]))
    else $error("peripheral not driving port 5 pin 5");
  AST_P5_LO: assert property (@(posedge clk_i) disable iff (rst_i)
    !io_mode[9]
    |=> pin_out_o[9] == $past(periph_out_i[9]))
    else $error("peripheral not driving port 5 pin 1");
  AST_P6_PIN5: assert property (@(posedge clk_i) disable iff (rst_i)
    !io_mode[21]
    |=> pin_oe_o[21] == $past(periph_oe_i[21]))
    else $error("peripheral not driving port 6 pin 5");

  // input gating
  AST_NOTIO: assert property (@(posedge clk_i) disable iff (rst_i)
    !io_mode[0]
    |=> !pin_filtered_o[0])
    else $error("function pin fed to peripheral input");
  AST_GATE5: assert property (@(posedge clk_i) disable iff (rst_i)
    q.p5_dir[0]
    |=> !pin_filtered_o[8])
    else $error("port 5 output pin fed to peripheral");
  AST_GATE6: assert property (@(posedge clk_i) disable iff (rst_i)
    q.p6_dir[1]
    |=> !pin_filtered_o[17])
    else $error("port 6 output pin fed to peripheral");

  // debounce
  AST_TICK_FX: assert property (@(posedge clk_i) disable iff (rst_i)
    debounce_clock_select_i == 2'b00
    |=> q.tick)
    else $error("no tick with the full rate clock");
  AST_DIV4: assert property (@(posedge clk_i) disable iff (rst_i)
    s_fx4_tick
    |=> !q.tick)
    else $error("divided tick too close");
  AST_FILT_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    s_in_p4 ##0 !q.db_en[0]
    |=> pin_filtered_o[3] == $past(q.pin_in[3]))
    else $error("unfiltered level not passed");
  AST_FILT_ON: assert property (@(posedge clk_i) disable iff (rst_i)
    s_in_p4 ##0 q.db_en[0]
    |=> pin_filtered_o[3] == $past(q.filt[0]))
    else $error("filtered level not passed");
  AST_FILT_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
    s_third
    |=> q.filt[0] == $past(d.pin_in[3]))
    else $error("level not taken on third tick");
  AST_FILT_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    !q.tick
    |=> $stable(q.filt))
    else $error("filter moved without a tick");
endmodule

// *** tb/tb.sv ***
// self-checking bench for the port 3 to 6 pin block
`timescale 1ns/10ps
`include "gpio_p456_consts.svh"
module tb;
  import gpio_p456_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic [22:0] pin_in = 23'h000000;
  logic [22:0] per_out = 23'h7FFFFF;
  logic [1:0] dbsel = 2'b00;
  logic stop = 1'b0;
  logic [22:0] pout, poe, ppu, pfilt;
  logic [3:0] p3sel;
  int n_mismatch = 0;
  int checks = 0;
  logic [15:0] ofs [19] = '{`OFS_P4_PU, `OFS_P5_PU, `OFS_P6_PU, `OFS_P4_DAT,
    `OFS_P5_DAT, `OFS_DB_EN, `OFS_P6_DAT, `OFS_P4_DIR, `OFS_P5_DIR,
    `OFS_P6_DIR, `OFS_P4_OD, `OFS_P5_OD, `OFS_P6_OD, `OFS_P3_FL,
    `OFS_P4_FL, `OFS_P4_FH, `OFS_P5_FL, `OFS_P5_FH, `OFS_P6_FH};
  logic [7:0] msk [19] = '{8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'h1F, 8'h7F,
    8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'h1F, 8'h7F, 8'h3F,
    8'h7F, 8'h07};

  always #20 clk_i = ~clk_i;

  gpio_p456 gpio_p456_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .debounce_clock_select_i(dbsel), .sub_clk_i(1'b0), .stop_mode_i(stop),
    .pin_in_i(pin_in), .pin_out_o(pout), .pin_oe_o(poe), .pin_pu_o(ppu),
    .periph_out_i(per_out), .periph_oe_i(23'h7FFFFF),
    .pin_filtered_o(pfilt), .p3_periph_sel_o(p3sel));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int t;
    t = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 50);
    q = rdat[7:0];
    if (t >= 50) n_mismatch++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk({24'h0, q}, {24'h0, exp});
  endtask

  task automatic drive(input logic [22:0] v);
    @(posedge clk_i);
    pin_in <= v;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // limit well above the few hundred cycles the tests take
  initial begin
    #(40 * 20000);
    n_mismatch++;
    end_sim();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 19; i++) begin
      rd(ofs[i], 8'h00);
      wr(ofs[i], 8'hFF);
      rd(ofs[i], msk[i]);
      wr(ofs[i], 8'h00);
    end
    rd(16'h1009, 8'h00);
    $display("test registers done");
    wr(`OFS_P4_DIR, 8'hFF);
    wr(`OFS_P4_DAT, 8'hA5);
    settle(3);
    chk(poe[7:0], 8'hFF);
    chk(pout[7:0], 8'hA5);
    wr(`OFS_P4_OD, 8'hFF);
    settle(3);
    chk(poe[7:0], 8'h5A);
    chk(pout[7:0], 8'h00);
    wr(`OFS_P5_PU, 8'h3C);
    wr(`OFS_P6_PU, 8'hFF);
    settle(3);
    chk(ppu[15:8], 8'h3C);
    chk(ppu[22:16], 7'h7F);
    $display("test drive done");
    wr(`OFS_P4_OD, 8'h00);
    wr(`OFS_P4_DAT, 8'h00);
    wr(`OFS_P4_FL, 8'h01);
    wr(`OFS_P4_FH, 8'h40);
    settle(3);
    chk(pout[7:0], 8'h81);
    chk(poe[7:0], 8'hFF);
    wr(`OFS_P3_FL, 8'hE4);
    settle(3);
    chk(p3sel, 4'hE);
    $display("test function select done");
    wr(`OFS_P4_FL, 8'h00);
    wr(`OFS_P4_FH, 8'h00);
    wr(`OFS_P4_DIR, 8'h00);
    drive(23'h010008);
    settle(12);
    chk(pfilt, 23'h010008);
    drive(23'h000000);
    wr(`OFS_DB_EN, 8'h01);
    settle(12);
    drive(23'h000008);
    @(posedge clk_i);
    drive(23'h000000);
    repeat (10) begin
      settle(1);
      chk(pfilt[3], 1'b0);
    end
    drive(23'h000008);
    settle(20);
    chk(pfilt[7:0], 8'h08);
    @(posedge clk_i);
    dbsel <= 2'b01;
    drive(23'h000000);
    settle(9);
    chk(pfilt[3], 1'b1);
    settle(15);
    chk(pfilt[3], 1'b0);
    @(posedge clk_i);
    dbsel <= 2'b00;
    stop <= 1'b1;
    drive(23'h000008);
    settle(20);
    chk(pfilt[3], 1'b0);
    @(posedge clk_i);
    stop <= 1'b0;
    settle(12);
    chk(pfilt[3], 1'b1);
    wr(`OFS_P4_DIR, 8'h08);
    settle(3);
    chk(pfilt[7:0], 8'h00);
    $display("test input filter done");
    end_sim();
  end
endmodule
